// *** logic/iovr_consts.vh ***
// Command codes, field positions, reset values and timing counts of the over-voltage responder.
`ifndef IOVR_CONSTS_VH
`define IOVR_CONSTS_VH

`define IOVR_CMD_OPERATION    8'h01
`define IOVR_CMD_CLEAR_FAULTS 8'h03
`define IOVR_CMD_OV_THRESHOLD 8'h55
`define IOVR_CMD_OV_ACTION    8'h56
`define IOVR_CMD_STATUS_INPUT 8'h7C
`define IOVR_CMD_TIME_UNIT    8'hC8

`define IOVR_RESP_HI   7
`define IOVR_RESP_LO   6
`define IOVR_RETRY_HI  5
`define IOVR_RETRY_LO  3
`define IOVR_DELAY_HI  2
`define IOVR_DELAY_LO  0
`define IOVR_OP_ON_BIT 7
`define IOVR_STAT_OV_BIT 7

`define IOVR_RESP_IGNORE  2'b00
`define IOVR_RESP_OPTHRU  2'b01
`define IOVR_RESP_DISABLE 2'b10
`define IOVR_RESP_LATCH   2'b11
`define IOVR_RETRY_NONE   3'b000
`define IOVR_RETRY_FOREVER 3'b111

`define IOVR_ACTION_RST    8'h80
`define IOVR_THRESHOLD_RST 16'h0BFF
`define IOVR_TIME_UNIT_RST 16'h0001
`define IOVR_OPERATION_RST 8'h80

`define IOVR_CLK_NS 4
`define IOVR_US_NS 1000
`define IOVR_US_CYCLES ((`IOVR_US_NS + `IOVR_CLK_NS - 1) / `IOVR_CLK_NS)

`endif

// *** logic/iovr_delay_timer.v ***
// Delay timer counting a power of two of time units, each unit a number of microseconds.
`timescale 1ns/10ps
`include "iovr_consts.vh"

module iovr_delay_timer (
  input wire mclk_i,            // Core clock.
  input wire srst_i,            // Synchronous reset, active high.
  input wire start_i,           // Restarts the delay from zero.
  input wire stop_i,            // Cancels a running delay.
  input wire [15:0] unit_us_i,  // Microseconds per time unit, zero taken as one.
  input wire [2:0] mult_sel_i,  // Delay is two to this power in units.
  output reg done_o             // One-cycle pulse when the delay ends.
);

  localparam integer US_LAST_INT = `IOVR_US_CYCLES - 1;
  localparam [7:0] US_LAST = US_LAST_INT[7:0];

  reg run_reg;
  reg [7:0] pre_reg;
  reg [15:0] sub_reg;
  reg [7:0] units_reg;
  wire [15:0] unit_last;
  wire [8:0] units_goal;

  assign unit_last = (unit_us_i == 16'h0000) ? 16'h0000 : unit_us_i - 16'h0001;
  assign units_goal = 9'h001 << mult_sel_i;

  always @(posedge mclk_i) begin
    done_o <= 1'b0;
    if (srst_i || stop_i) begin
      run_reg <= 1'b0;
      pre_reg <= 8'h00;
      sub_reg <= 16'h0000;
      units_reg <= 8'h00;
    end else if (start_i) begin
      run_reg <= 1'b1;
      pre_reg <= 8'h00;
      sub_reg <= 16'h0000;
      units_reg <= 8'h00;
    end else if (run_reg) begin
      if (pre_reg == US_LAST) begin
        pre_reg <= 8'h00;
        if (sub_reg == unit_last) begin
          sub_reg <= 16'h0000;
          if ({1'b0, units_reg} + 9'h001 == units_goal) begin
            done_o <= 1'b1;
            run_reg <= 1'b0;
            units_reg <= 8'h00;
          end else begin
            units_reg <= units_reg + 8'h01;
          end
        end else begin
          sub_reg <= sub_reg + 16'h0001;
        end
      end else begin
        pre_reg <= pre_reg + 8'h01;
      end
    end
  end

endmodule // iovr_delay_timer

// *** logic/iovr_responder.v ***
// Input over-voltage fault responder with its command registers.
// Behaviour
// - Response 00 keeps the output running through an over-voltage fault.
// - Response 01 runs for the delay, then applies retry setting if fault remains.
// - Response 10 disables output at once, then follows the retry setting.
// - Response 11 disables output until the fault is cleared.
// - Status clear, clear-faults, reset pin, off-then-on or power loss clear the fault.
// - Retry setting 000 never restarts; output stays off until cleared.
// - Retry settings 1 to 6 try that many restarts, stopping on success.
// - When all restart attempts fail, output stays off until cleared.
// - Retry setting 111 retries until commanded off, power loss or other shutdown.
// - Restart attempts start one delay apart, two to the delay field times time unit.
// - Delay field value n gives two to the n time units.
// - One delay serves both the run-through time and the restart spacing.
// - The time unit length comes from the separate time-unit register.
// - The 8-bit action setting is written at command code 0x56.
// - Fault is input above a 16-bit linear threshold at code 0x55.
`timescale 1ns/10ps
`include "iovr_consts.vh"

module iovr_responder (
  input wire mclk_i,              // Core clock, 250 MHz.
  input wire srst_i,              // Synchronous reset from bias power, active high.
  input wire cmd_wr_i,            // Command write strobe.
  input wire cmd_rd_i,            // Command read strobe.
  input wire [7:0] cmd_code_i,    // Command code.
  input wire [15:0] cmd_data_i,   // Command write data.
  input wire [15:0] vin_i,        // Input voltage sample, linear format.
  input wire vin_valid_i,         // Input voltage sample strobe.
  input wire ctrl_pin_i,          // Enable pin, asynchronous, high is on.
  input wire reset_pin_n_i,       // Reset pin, asynchronous, active low.
  input wire other_shutdown_i,    // Another fault has shut the unit down.
  output reg [15:0] rd_data_o,    // Read data.
  output reg rd_valid_o,          // Read data valid pulse.
  output reg output_en_o,         // Power output enable.
  output reg ov_fault_o,          // Latched over-voltage status bit.
  output reg retrying_o           // Output held off between restart attempts.
);

  // Response states.
  localparam [1:0] ST_RUN = 2'b00;
  localparam [1:0] ST_THRU = 2'b01;
  localparam [1:0] ST_RETRY = 2'b10;
  localparam [1:0] ST_LATCH = 2'b11;

  // Command registers.
  reg [7:0] action_reg;
  reg [15:0] threshold_reg;
  reg [15:0] unit_reg;
  reg [7:0] operation_reg;

  // Pin synchronisers.
  reg ctrl_meta_reg;
  reg ctrl_sync_reg;
  reg rstp_meta_reg;
  reg rstp_sync_reg;

  // Fault detection and response state.
  reg ov_reg;
  reg ov_next;
  reg ov_prev_reg;
  reg on_prev_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [2:0] tries_reg;
  reg [2:0] tries_next;
  reg status_reg;
  reg status_next;
  reg timer_start;
  reg op_next_on;

  // Decoded fields and events.
  wire [1:0] resp_sel;
  wire [2:0] retry_sel;
  wire [2:0] delay_sel;
  wire on_now;
  wire status_clr;
  wire clear_faults;
  wire clear_evt;
  wire off_evt;
  wire timer_done;
  wire wr_status;
  wire ov_rise;
  wire retry_spent;

  // Field decode, and every event that clears a latched fault.
  assign resp_sel = action_reg[`IOVR_RESP_HI:`IOVR_RESP_LO];
  assign retry_sel = action_reg[`IOVR_RETRY_HI:`IOVR_RETRY_LO];
  assign delay_sel = action_reg[`IOVR_DELAY_HI:`IOVR_DELAY_LO];
  assign on_now = ctrl_sync_reg & operation_reg[`IOVR_OP_ON_BIT];
  // The off edge itself counts as the clear, so the later on edge starts afresh.
  assign off_evt = on_prev_reg & ~on_now;
  assign wr_status = cmd_wr_i && (cmd_code_i == `IOVR_CMD_STATUS_INPUT);
  assign status_clr = wr_status && cmd_data_i[`IOVR_STAT_OV_BIT];
  assign clear_faults = cmd_wr_i && (cmd_code_i == `IOVR_CMD_CLEAR_FAULTS);
  assign clear_evt = status_clr | clear_faults | rstp_sync_reg | off_evt;
  assign ov_rise = ov_reg & ~ov_prev_reg;
  // The last permitted attempt has been used once the count plus one, for the current attempt, reaches the retry setting.
  assign retry_spent = (tries_reg + 3'b001) >= retry_sel;

  // Linear value to a common fixed-point scale: mantissa shifted by exponent plus sixteen.
  function signed [47:0] lin_fixed;
    input [15:0] v;
    reg signed [47:0] m;
    begin
      m = {{37{v[10]}}, v[10:0]};
      lin_fixed = m <<< (v[15:11] ^ 5'h10);
    end
  endfunction

  // The timer idles while the unit is commanded off or a clear arrives, so each fault starts a fresh delay.
  iovr_delay_timer u_timer (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .start_i(timer_start),
    .stop_i(clear_evt | ~on_now),
    .unit_us_i(unit_reg),
    .mult_sel_i(delay_sel),
    .done_o(timer_done)
  );

  // Pins from outside the clock domain pass two flip-flops first.
  always @(posedge mclk_i) begin
    if (srst_i) begin
      ctrl_meta_reg <= 1'b0;
      ctrl_sync_reg <= 1'b0;
      rstp_meta_reg <= 1'b0;
      rstp_sync_reg <= 1'b0;
    end else begin
      ctrl_meta_reg <= ctrl_pin_i;
      ctrl_sync_reg <= ctrl_meta_reg;
      rstp_meta_reg <= ~reset_pin_n_i;
      rstp_sync_reg <= rstp_meta_reg;
    end
  end

  // Command register writes.
  // Unknown codes are ignored, and 8-bit commands take the low byte only.
  always @(posedge mclk_i) begin
    if (srst_i) begin
      action_reg <= `IOVR_ACTION_RST;
      threshold_reg <= `IOVR_THRESHOLD_RST;
      unit_reg <= `IOVR_TIME_UNIT_RST;
      operation_reg <= `IOVR_OPERATION_RST;
    end else if (cmd_wr_i) begin
      if (cmd_code_i == `IOVR_CMD_OV_ACTION) begin
        action_reg <= cmd_data_i[7:0];
      end else if (cmd_code_i == `IOVR_CMD_OV_THRESHOLD) begin
        threshold_reg <= cmd_data_i;
      end else if (cmd_code_i == `IOVR_CMD_TIME_UNIT) begin
        unit_reg <= cmd_data_i;
      end else if (cmd_code_i == `IOVR_CMD_OPERATION) begin
        operation_reg <= cmd_data_i[7:0];
      end
    end
  end

  // Command register reads, one cycle after the strobe.
  // Unknown codes read as zero.
  always @(posedge mclk_i) begin
    if (srst_i) begin
      rd_data_o <= 16'h0000;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= cmd_rd_i;
      if (cmd_rd_i) begin
        if (cmd_code_i == `IOVR_CMD_OV_ACTION) begin
          rd_data_o <= {8'h00, action_reg};
        end else if (cmd_code_i == `IOVR_CMD_OV_THRESHOLD) begin
          rd_data_o <= threshold_reg;
        end else if (cmd_code_i == `IOVR_CMD_TIME_UNIT) begin
          rd_data_o <= unit_reg;
        end else if (cmd_code_i == `IOVR_CMD_OPERATION) begin
          rd_data_o <= {8'h00, operation_reg};
        end else if (cmd_code_i == `IOVR_CMD_STATUS_INPUT) begin
          rd_data_o <= {8'h00, status_reg, 7'h00};
        end else begin
          rd_data_o <= 16'h0000;
        end
      end
    end
  end

  // Threshold comparison on each fresh sample.
  always @* begin
    ov_next = ov_reg;
    if (vin_valid_i) begin
      ov_next = lin_fixed(vin_i) > lin_fixed(threshold_reg);
    end
  end

  // Fault response sequencing.
  always @* begin
    state_next = state_reg;
    tries_next = tries_reg;
    timer_start = 1'b0;
    // A fault edge in the same cycle as a clear wins, so no new fault is lost.
    status_next = ov_rise | (status_reg & ~clear_evt);
    if (clear_evt || !on_now) begin
      state_next = ST_RUN;
      tries_next = 3'b000;
    // Another shutdown ends retrying and holds the output off.
    end else if (other_shutdown_i && state_reg == ST_RETRY) begin
      state_next = ST_LATCH;
    end else begin
      case (state_reg)
        // Normal running: a fault picks the configured response.
        ST_RUN: begin
          if (ov_reg) begin
            if (resp_sel == `IOVR_RESP_OPTHRU) begin
              state_next = ST_THRU;
              timer_start = 1'b1;
            end else if (resp_sel == `IOVR_RESP_DISABLE) begin
              tries_next = 3'b000;
              if (retry_sel == `IOVR_RETRY_NONE) begin
                state_next = ST_LATCH;
              end else begin
                state_next = ST_RETRY;
                timer_start = 1'b1;
              end
            end else if (resp_sel == `IOVR_RESP_LATCH) begin
              state_next = ST_LATCH;
            end
          end
        end
        // Running on through the fault for one delay.
        ST_THRU: begin
          if (timer_done) begin
            tries_next = 3'b000;
            if (!ov_reg) begin
              state_next = ST_RUN;
            end else if (retry_sel == `IOVR_RETRY_NONE) begin
              state_next = ST_LATCH;
            end else begin
              state_next = ST_RETRY;
              timer_start = 1'b1;
            end
          end
        end
        // Output off; each end of the delay is one restart attempt.
        ST_RETRY: begin
          if (timer_done) begin
            if (!ov_reg) begin
              state_next = ST_RUN;
              tries_next = 3'b000;
            end else if (retry_sel == `IOVR_RETRY_FOREVER) begin
              timer_start = 1'b1;
            end else if (retry_spent) begin
              state_next = ST_LATCH;
            end else begin
              tries_next = tries_reg + 3'b001;
              timer_start = 1'b1;
            end
          end
        end
        // Latched off until a clear, which is handled above.
        ST_LATCH: begin
          state_next = ST_LATCH;
        end
        default: begin
          state_next = ST_LATCH;
        end
      endcase
    end
    // The output runs only in normal running and during the run-through delay.
    op_next_on = on_now && (state_next == ST_RUN || state_next == ST_THRU);
  end

  // Fault state registers.
  always @(posedge mclk_i) begin
    if (srst_i) begin
      ov_reg <= 1'b0;
      ov_prev_reg <= 1'b0;
      on_prev_reg <= 1'b0;
      state_reg <= ST_RUN;
      tries_reg <= 3'b000;
      status_reg <= 1'b0;
    end else begin
      ov_reg <= ov_next;
      ov_prev_reg <= ov_reg;
      on_prev_reg <= on_now;
      state_reg <= state_next;
      tries_reg <= tries_next;
      status_reg <= status_next;
    end
  end

  // Outputs take the next-state values, so they change in the same cycle as the state.
  always @(posedge mclk_i) begin
    if (srst_i) begin
      output_en_o <= 1'b0;
      ov_fault_o <= 1'b0;
      retrying_o <= 1'b0;
    end else begin
      output_en_o <= op_next_on;
      ov_fault_o <= status_next;
      retrying_o <= (state_next == ST_RETRY);
    end
  end

endmodule // iovr_responder

// *** verif/iovr_monitor.sv ***
// Port-level checker of the over-voltage responder, bound to its top module.
`timescale 1ns/10ps
module iovr_monitor (
  input wire mclk_i,            // Core clock.
  input wire srst_i,            // Synchronous reset.
  input wire cmd_wr_i,          // Write strobe.
  input wire cmd_rd_i,          // Read strobe.
  input wire [7:0] cmd_code_i,  // Command code.
  input wire [15:0] cmd_data_i, // Write data.
  input wire [15:0] rd_data_o,  // Read data.
  input wire rd_valid_o,        // Read data valid.
  input wire output_en_o,       // Output enable.
  input wire ov_fault_o,        // Fault status.
  input wire retrying_o         // Restart wait.
);
  reg [7:0] act_reg;
  always @(posedge mclk_i) begin
    if (srst_i)
      act_reg <= 8'h80;
    else if (cmd_wr_i && cmd_code_i == 8'h56)
      act_reg <= cmd_data_i[7:0];
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence s_read;
    cmd_rd_i ##1 rd_valid_o;
  endsequence
  a_read_answer: assert property (cmd_rd_i |-> s_read) else $error("read not answered");
  a_valid_cause: assert property (rd_valid_o |-> $past(cmd_rd_i)) else $error("stray read valid");
  a_reset_outputs: assert property (disable iff (1'b0) srst_i |=> !output_en_o && !ov_fault_o && !retrying_o)
    else $error("outputs not cleared by reset");
  a_unknown_zero: assert property (cmd_rd_i && !(cmd_code_i inside {8'h01, 8'h03, 8'h55, 8'h56, 8'h7C, 8'hC8})
    |=> rd_data_o == 16'h0000) else $error("unknown code read not zero");
  a_action_readback: assert property (cmd_rd_i && cmd_code_i == 8'h56 |=> rd_data_o == {8'h00, act_reg})
    else $error("action read back wrong");
  a_retry_off: assert property (retrying_o |-> !output_en_o) else $error("output on while waiting");
  a_ignore_run: assert property (act_reg[7:6] == 2'b00 && !retrying_o |=> !retrying_o)
    else $error("retry under ignore response");
  a_latch_hold: assert property (act_reg[7:6] == 2'b11 && !retrying_o |=> !retrying_o)
    else $error("retry under latch response");
  a_noretry_hold: assert property (act_reg[5:3] == 3'b000 && !retrying_o |=> !retrying_o)
    else $error("retry with zero retries");
  a_retry_min: assert property ($rose(retrying_o) |-> retrying_o [*8]) else $error("restart wait too short");
  a_clear_cmd: assert property (cmd_wr_i && cmd_code_i == 8'h03 |-> ##[1:2] !ov_fault_o)
    else $error("clear faults ignored");
endmodule // iovr_monitor
bind iovr_responder iovr_monitor u_mon (.mclk_i(mclk_i), .srst_i(srst_i), .cmd_wr_i(cmd_wr_i),
  .cmd_rd_i(cmd_rd_i), .cmd_code_i(cmd_code_i), .cmd_data_i(cmd_data_i), .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o), .output_en_o(output_en_o), .ov_fault_o(ov_fault_o), .retrying_o(retrying_o));

// *** verif/iovr_vin_source.sv ***
// Input voltage sampler model feeding one sample every 80 ns.
`timescale 1ns/10ps
module iovr_vin_source (
  input wire clk_i,        // Core clock.
  input wire over_i,       // Asks for an over-voltage level.
  output reg [15:0] vin_o, // Sample value, garbage between strobes.
  output reg valid_o       // Sample strobe.
);
  reg [4:0] cnt_reg = 5'h00;
  initial vin_o = 16'h0000;
  initial valid_o = 1'b0;
  always @(negedge clk_i) begin
    cnt_reg <= (cnt_reg == 5'h13) ? 5'h00 : cnt_reg + 5'h01;
    valid_o <= (cnt_reg == 5'h13);
    vin_o <= (cnt_reg == 5'h13) ? (over_i ? 16'h13FF : 16'h0900) : ~vin_o;
  end
endmodule // iovr_vin_source

// *** verif/testbench.sv ***
// Self-checking bench of the over-voltage responder.
`timescale 1ns/10ps
module testbench;
  reg mclk_i = 0, srst_i = 1, cmd_wr_i = 0, cmd_rd_i = 0, ctrl_pin_i = 1, reset_pin_n_i = 1;
  reg other_shutdown_i = 0, over = 0;
  reg [7:0] cmd_code_i = 8'h00;
  reg [15:0] cmd_data_i = 16'h0000;
  wire [15:0] vin_i, rd_data_o;
  wire vin_valid_i, rd_valid_o, output_en_o, ov_fault_o, retrying_o;
  integer failures = 0, checked = 0, cyc = 0, n, t;
  always #2 mclk_i = ~mclk_i;
  iovr_vin_source u_src (.clk_i(mclk_i), .over_i(over), .vin_o(vin_i), .valid_o(vin_valid_i));
  iovr_responder u_dut (.mclk_i(mclk_i), .srst_i(srst_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i),
    .cmd_code_i(cmd_code_i), .cmd_data_i(cmd_data_i), .vin_i(vin_i), .vin_valid_i(vin_valid_i),
    .ctrl_pin_i(ctrl_pin_i), .reset_pin_n_i(reset_pin_n_i), .other_shutdown_i(other_shutdown_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .output_en_o(output_en_o), .ov_fault_o(ov_fault_o),
    .retrying_o(retrying_o));
  task complete_run;
    begin
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task idle(input integer c);
    repeat (c) @(negedge mclk_i);
  endtask
  task wr(input [7:0] c, input [15:0] d);
    begin
      @(negedge mclk_i);
      cmd_wr_i = 1;
      cmd_code_i = c;
      cmd_data_i = d;
      @(negedge mclk_i);
      cmd_wr_i = 0;
    end
  endtask
  // Read data is compared in the one cycle that the valid pulse stands.
  task rd_chk(input [7:0] c, input [15:0] exp);
    begin
      @(negedge mclk_i);
      cmd_rd_i = 1;
      cmd_code_i = c;
      @(negedge mclk_i);
      cmd_rd_i = 0;
      chk(rd_valid_o, 1);
      chk(rd_data_o, exp);
    end
  endtask
  task wait_off;
    begin
      t = 0;
      while (output_en_o !== 1'b0 && t < 100) begin
        @(negedge mclk_i);
        t = t + 1;
      end
      chk(output_en_o, 0);
    end
  endtask
  task clear_on;
    begin
      over = 0;
      idle(30);
      wr(8'h03, 16'h0000);
      idle(4);
      chk(output_en_o, 1);
    end
  endtask
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      failures = failures + 1;
      complete_run;
    end
  end
  initial begin
    idle(12);
    srst_i = 0;
    idle(10);
    chk(output_en_o, 1);
    rd_chk(8'h56, 16'h0080);
    rd_chk(8'h55, 16'h0BFF);
    rd_chk(8'hC8, 16'h0001);
    rd_chk(8'h20, 16'h0000);
    wr(8'h56, 16'h0091);
    rd_chk(8'h56, 16'h0091);
    wr(8'h56, 16'h0000);
    wr(8'h55, 16'h1BFF);
    rd_chk(8'h55, 16'h1BFF);
    over = 1;
    idle(60);
    chk(ov_fault_o, 0);
    wr(8'h55, 16'h0BFF);
    idle(60);
    chk(output_en_o, 1);
    chk(ov_fault_o, 1);
    rd_chk(8'h7C, 16'h0080);
    clear_on;
    chk(ov_fault_o, 0);
    wr(8'h56, 16'h00C0);
    over = 1;
    wait_off;
    over = 0;
    idle(600);
    chk({retrying_o, output_en_o}, 0);
    wr(8'h7C, 16'h0080);
    idle(4);
    chk(output_en_o, 1);
    wr(8'h56, 16'h0080);
    over = 1;
    wait_off;
    idle(300);
    chk(output_en_o, 0);
    over = 0;
    idle(30);
    reset_pin_n_i = 0;
    idle(4);
    reset_pin_n_i = 1;
    idle(6);
    chk(output_en_o, 1);
    for (n = 1; n <= 6; n = n + 1) begin
      wr(8'h56, {8'h00, 2'b10, n[2:0], 3'b000});
      over = 1;
      wait_off;
      idle(n * 250 - 12);
      chk(retrying_o, 1);
      idle(24);
      chk({retrying_o, output_en_o}, 0);
      clear_on;
    end
    wr(8'h56, 16'h008A);
    over = 1;
    wait_off;
    over = 0;
    idle(985);
    chk(output_en_o, 0);
    idle(30);
    chk({retrying_o, output_en_o}, 1);
    wr(8'hC8, 16'h0002);
    rd_chk(8'hC8, 16'h0002);
    wr(8'h56, 16'h0088);
    over = 1;
    wait_off;
    over = 0;
    idle(485);
    chk(output_en_o, 0);
    idle(30);
    chk(output_en_o, 1);
    wr(8'hC8, 16'h0001);
    wr(8'h56, 16'h0041);
    over = 1;
    idle(470);
    chk(output_en_o, 1);
    idle(60);
    chk(output_en_o, 0);
    clear_on;
    wr(8'h56, 16'h00B8);
    over = 1;
    wait_off;
    idle(1800);
    chk(retrying_o, 1);
    ctrl_pin_i = 0;
    idle(8);
    chk(retrying_o, 0);
    over = 0;
    idle(30);
    ctrl_pin_i = 1;
    idle(10);
    chk(output_en_o, 1);
    over = 1;
    wait_off;
    idle(20);
    wr(8'h01, 16'h0000);
    idle(2);
    chk(retrying_o, 0);
    over = 0;
    idle(30);
    wr(8'h01, 16'h0080);
    rd_chk(8'h01, 16'h0080);
    idle(2);
    chk(output_en_o, 1);
    over = 1;
    wait_off;
    idle(20);
    other_shutdown_i = 1;
    idle(4);
    chk({retrying_o, output_en_o}, 0);
    other_shutdown_i = 0;
    clear_on;
    complete_run;
  end
endmodule // testbench
